// file: hw/smw_pkg.sv
// Package for the serial mute, wake-up and parity unit.
// Assumes an AXI4-Lite master with 32-bit data and the CPU clock at 25 MHz.
package smw_pkg;
  localparam logic [7:0] SMW_STATUS_OFS = 8'h00;
  localparam logic [7:0] SMW_DATA_OFS = 8'h04;
  localparam logic [7:0] SMW_CTRL1_OFS = 8'h08;
  localparam logic [7:0] SMW_CTRL2_OFS = 8'h0C;
  localparam logic [7:0] SMW_BAUD_OFS = 8'h10;
  localparam logic [7:0] SMW_STATUS_RST = 8'hC0;
  localparam logic [7:0] SMW_CTRL1_RST = 8'h00;
  localparam logic [7:0] SMW_CTRL2_RST = 8'h00;
  localparam int SMW_TXE_BIT = 7;
  localparam int SMW_TXC_BIT = 6;
  localparam int SMW_RXF_BIT = 5;
  localparam int SMW_IDLE_BIT = 4;
  localparam int SMW_OR_BIT = 3;
  localparam int SMW_NF_BIT = 2;
  localparam int SMW_FE_BIT = 1;
  localparam int SMW_PERR_BIT = 0;
  localparam int SMW_C1_RX9 = 7;
  localparam int SMW_C1_TX9 = 6;
  localparam int SMW_C1_M = 4;
  localparam int SMW_C1_WAKE = 3;
  localparam int SMW_C1_PAREN = 2;
  localparam int SMW_C1_PODD = 1;
  localparam int SMW_C1_PARIRQ = 0;
  localparam int SMW_C2_TXEIRQ = 7;
  localparam int SMW_C2_TXCIRQ = 6;
  localparam int SMW_C2_RXIRQ = 5;
  localparam int SMW_C2_QUIETIRQ = 4;
  localparam int SMW_C2_OVRIRQ = 3;
  localparam int SMW_C2_LINIRQ = 2;
  localparam int SMW_C2_MUTE = 1;
  localparam logic [15:0] SMW_BAUD_RST = 16'h00D9;
  localparam logic [1:0] SMW_RESP_OKAY = 2'b00;
  localparam logic [1:0] SMW_RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {SMW_RX_IDLE, SMW_RX_DATA, SMW_RX_STOP} smw_rx_e;
endpackage

// file: hw/smw_top.sv
// Serial unit with receive mute, wake-up, parity and interrupt gating.
// Assumes an AXI4-Lite master on clk and asynchronous rxd/halt/wait pins.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Setting mute request makes receiver ignore incoming characters.
// - While muted no receive flag sets and receive interrupts are suppressed.
// - Wake on idle line if wake select clear, on address mark if set.
// - Idle wake clears mute request without setting idle flag.
// - Address word with top bit one wakes, clears mute, sets receive full.
// - A break character is never taken as an address word.
// - Parity enable turns on parity generation and checking.
// - Frame is start, 8 or 9 bits including optional parity, stop.
// - Address mark uses the top data bit, not the parity position.
// - Parity makes ones count even when select is 0, odd when 1.
// - With parity on, transmitted top bit is replaced by parity.
// - Parity mismatch sets parity error, interrupt if its enable set.
// - In Wait the unit runs and enabled interrupts wake the device.
// - In Halt registers freeze and traffic stops; events do not end Halt; the register bus still writes registers and clears flags in Halt.
// - Each event flag except noise and framing pairs with its own interrupt enable; the line enable is gated by zero.
// - All events merge onto one interrupt request line.
// - Interrupt needs enable set and processor mask cleared.
// - Overrun wakes from Wait but not from Halt.
// - Long words keep the ninth received bit in its own field.
// - Parity error clears after status access then data access.
// - Receive flags clear after status access then data read.
module smw_top (
  input wire logic clk, // CPU clock
  input wire logic rst_n, // Async reset, active low
  input wire logic clk_en, // Freezes all state when low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic rxd, // Serial receive pin
  output logic txd, // Serial transmit pin
  input wire logic halt_req, // Device in Halt
  input wire logic wait_req, // Device in Wait
  input wire logic cpu_int_mask, // Processor interrupt mask, high masks
  output logic irq, // Merged interrupt request
  output logic wait_wake // Wake from Wait request
);
  import smw_pkg::*;
  logic [2:0] rx_sync_r, halt_sync_r, wait_sync_r;
  logic rx_s_r, halt_r, wait_r;
  logic run;
  logic [7:0] status_r, ctrl1_r, ctrl2_r;
  logic [15:0] baud_r;
  logic [8:0] rdr_r, tdr_r;
  logic status_seen_r;
  logic aw_got_r, w_got_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_go, rd_go, data_wr, data_rd, stat_rd;
  logic word9, par_en, mute;
  // Three-stage sync; a change counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sync_r <= 3'h7;
      halt_sync_r <= 3'h0;
      wait_sync_r <= 3'h0;
    end else if (clk_en) begin
      rx_sync_r <= {rx_sync_r[1:0], rxd};
      halt_sync_r <= {halt_sync_r[1:0], halt_req};
      wait_sync_r <= {wait_sync_r[1:0], wait_req};
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s_r <= 1'b1;
      halt_r <= 1'b0;
      wait_r <= 1'b0;
    end else if (clk_en) begin
      if (rx_sync_r[1] == rx_sync_r[2]) rx_s_r <= rx_sync_r[2];
      if (halt_sync_r[1] == halt_sync_r[2]) halt_r <= halt_sync_r[2];
      if (wait_sync_r[1] == wait_sync_r[2]) wait_r <= wait_sync_r[2];
    end
  end
  assign run = clk_en && !halt_r;
  assign word9 = ctrl1_r[SMW_C1_M];
  assign par_en = ctrl1_r[SMW_C1_PAREN];
  assign mute = ctrl2_r[SMW_C2_MUTE];
  // AXI write: address and data taken in either order; register bus keeps working in Halt
  assign wr_go = aw_got_r && w_got_r && !s_axi_bvalid;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SMW_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr_r)
          SMW_STATUS_OFS, SMW_DATA_OFS, SMW_CTRL1_OFS, SMW_CTRL2_OFS, SMW_BAUD_OFS:
            s_axi_bresp <= SMW_RESP_OKAY;
          default: s_axi_bresp <= SMW_RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  assign rd_go = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= SMW_RESP_OKAY;
    end else if (clk_en) begin
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= SMW_RESP_OKAY;
        case (s_axi_araddr)
          SMW_STATUS_OFS: s_axi_rdata <= {24'h000000, status_r};
          SMW_DATA_OFS: s_axi_rdata <= {24'h000000, rdr_r[7:0]};
          SMW_CTRL1_OFS: s_axi_rdata <= {24'h000000, rdr_r[8], ctrl1_r[6:0]};
          SMW_CTRL2_OFS: s_axi_rdata <= {24'h000000, ctrl2_r};
          SMW_BAUD_OFS: s_axi_rdata <= {16'h0000, baud_r};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= SMW_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
  assign data_wr = wr_go && aw_addr_r == SMW_DATA_OFS && w_strb_r[0];
  assign data_rd = rd_go && s_axi_araddr == SMW_DATA_OFS;
  assign stat_rd = rd_go && s_axi_araddr == SMW_STATUS_OFS;
  // Status access arms the clear sequence; the next data access completes it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) status_seen_r <= 1'b0;
    else if (clk_en) begin
      if (stat_rd) status_seen_r <= 1'b1;
      else if (data_rd || data_wr) status_seen_r <= 1'b0;
    end
  end
  // Receiver: 16x oversampling, majority of samples 7..9, noise if they disagree
  smw_rx_e rx_st_r;
  logic [15:0] rx_div_r;
  logic [3:0] rx_os_r, rx_bit_r;
  logic [8:0] rx_sh_r;
  logic [2:0] rx_smp_r;
  logic rx_noise_r, rx_last_r, rx_tick, rx_maj, rx_done, rx_fe;
  logic [3:0] rx_nbits;
  logic [3:0] idle_cnt_r;
  logic idle_armed_r, idle_seen;
  assign rx_nbits = word9 ? 4'h9 : 4'h8;
  assign rx_tick = rx_div_r == 16'h0000;
  assign rx_maj = (rx_smp_r[0] & rx_smp_r[1]) | (rx_smp_r[1] & rx_smp_r[2])
    | (rx_smp_r[0] & rx_smp_r[2]);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rx_div_r <= 16'h0000;
    else if (run) rx_div_r <= rx_tick ? baud_r : rx_div_r - 16'h0001;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_r <= SMW_RX_IDLE;
      rx_os_r <= 4'h0;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 9'h000;
      rx_smp_r <= 3'h0;
      rx_noise_r <= 1'b0;
      rx_last_r <= 1'b1;
    end else if (run && rx_tick) begin
      rx_os_r <= rx_os_r + 4'h1;
      rx_last_r <= rx_s_r;
      if (rx_os_r >= 4'h7 && rx_os_r <= 4'h9) rx_smp_r <= {rx_smp_r[1:0], rx_s_r};
      case (rx_st_r)
        SMW_RX_IDLE: begin
          // Phase keeps running so idle time is counted in whole bits; a start
          // needs a falling edge, so a line left low by a break starts nothing
          if (rx_last_r && !rx_s_r) begin
            rx_st_r <= SMW_RX_DATA;
            rx_os_r <= 4'h1;
            rx_bit_r <= 4'h0;
            rx_noise_r <= 1'b0;
          end
        end
        SMW_RX_DATA: if (rx_os_r == 4'hF) begin
          if (rx_smp_r[0] != rx_smp_r[1] || rx_smp_r[1] != rx_smp_r[2]) rx_noise_r <= 1'b1;
          if (rx_bit_r != 4'h0) rx_sh_r <= word9 ? {rx_maj, rx_sh_r[8:1]}
            : {1'b0, rx_maj, rx_sh_r[7:1]};
          if (rx_bit_r == rx_nbits) rx_st_r <= SMW_RX_STOP;
          rx_bit_r <= rx_bit_r + 4'h1;
        end
        SMW_RX_STOP: if (rx_os_r == 4'h9) rx_st_r <= SMW_RX_IDLE;
        default: rx_st_r <= SMW_RX_IDLE;
      endcase
    end
  end
  assign rx_done = run && rx_tick && rx_st_r == SMW_RX_STOP && rx_os_r == 4'h9;
  assign rx_fe = !rx_maj;
  // Idle: a full character of ones; armed again only after a character
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt_r <= 4'h0;
      idle_armed_r <= 1'b0;
    end else if (run && rx_tick) begin
      if (rx_st_r != SMW_RX_IDLE || !rx_s_r) idle_cnt_r <= 4'h0;
      else if (rx_os_r == 4'hF && idle_cnt_r != 4'hF) idle_cnt_r <= idle_cnt_r + 4'h1;
      if (rx_done) idle_armed_r <= 1'b1;
      else if (idle_seen) idle_armed_r <= 1'b0;
    end
  end
  assign idle_seen = run && rx_tick && rx_os_r == 4'hF && rx_st_r == SMW_RX_IDLE
    && rx_s_r && idle_cnt_r == rx_nbits + 4'h1 && idle_armed_r;
  logic [7:0] low_bits;
  logic rx_par_pos, rx_top, rx_brk, rx_addr, rx_par_bad, accept, rx_clr, tx_clr;
  assign low_bits = word9 ? rx_sh_r[7:0] : {1'b0, rx_sh_r[6:0]};
  assign rx_par_pos = word9 ? rx_sh_r[8] : rx_sh_r[7];
  // With parity on, the address mark is the data bit just below the parity slot
  assign rx_top = !par_en ? rx_par_pos : word9 ? rx_sh_r[7] : rx_sh_r[6];
  assign rx_brk = rx_sh_r == 9'h000 && rx_fe;
  assign rx_addr = ctrl1_r[SMW_C1_WAKE] && rx_top && !rx_brk;
  assign rx_par_bad = par_en && ((^low_bits) ^ rx_par_pos ^ ctrl1_r[SMW_C1_PODD]);
  assign accept = rx_done && (!mute || rx_addr);
  assign rx_clr = status_seen_r && data_rd;
  assign tx_clr = status_seen_r && data_wr;
  // Receive flags: a set in the same cycle as a clear wins
  logic tx_load, tx_done, tx_busy_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= SMW_STATUS_RST;
      rdr_r <= 9'h000;
    end else if (clk_en) begin
      if (rx_clr) status_r[SMW_RXF_BIT:SMW_FE_BIT] <= 5'h00;
      if (status_seen_r && (data_rd || data_wr)) status_r[SMW_PERR_BIT] <= 1'b0;
      if (tx_clr) status_r[SMW_TXC_BIT] <= 1'b0;
      if (tx_clr && tx_busy_r) status_r[SMW_TXE_BIT] <= 1'b0;
      if (tx_load) status_r[SMW_TXE_BIT] <= 1'b1;
      if (tx_done) status_r[SMW_TXC_BIT] <= 1'b1;
      if (accept) begin
        if (status_r[SMW_RXF_BIT] && !rx_clr) status_r[SMW_OR_BIT] <= 1'b1;
        else begin
          rdr_r <= rx_sh_r;
          status_r[SMW_RXF_BIT] <= 1'b1;
          status_r[SMW_NF_BIT] <= rx_noise_r;
          status_r[SMW_FE_BIT] <= rx_fe;
          if (rx_par_bad) status_r[SMW_PERR_BIT] <= 1'b1;
        end
      end
      if (idle_seen && !mute) status_r[SMW_IDLE_BIT] <= 1'b1;
    end
  end
  // Control registers; hardware clear of the mute request wins over the write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1_r <= SMW_CTRL1_RST;
      ctrl2_r <= SMW_CTRL2_RST;
      baud_r <= SMW_BAUD_RST;
    end else if (clk_en) begin
      if (wr_go && w_strb_r[0] && aw_addr_r == SMW_CTRL1_OFS) ctrl1_r <= w_data_r[7:0];
      if (wr_go && w_strb_r[0] && aw_addr_r == SMW_CTRL2_OFS) ctrl2_r <= w_data_r[7:0];
      if (wr_go && aw_addr_r == SMW_BAUD_OFS) begin
        if (w_strb_r[0]) baud_r[7:0] <= w_data_r[7:0];
        if (w_strb_r[1]) baud_r[15:8] <= w_data_r[15:8];
      end
      if (mute && ((!ctrl1_r[SMW_C1_WAKE] && idle_seen) || (rx_done && rx_addr)))
        ctrl2_r[SMW_C2_MUTE] <= 1'b0;
    end
  end
  // Transmitter with one holding word; parity replaces the top data bit
  logic [8:0] tx_word, tx_hold_r;
  logic [10:0] tx_sh_r;
  logic [15:0] tx_div_r;
  logic [3:0] tx_os_r, tx_cnt_r;
  logic tx_full_r, tx_par;
  assign tx_par = (^(word9 ? tx_hold_r[7:0] : {1'b0, tx_hold_r[6:0]}))
    ^ ctrl1_r[SMW_C1_PODD];
  assign tx_word = !par_en ? tx_hold_r : word9 ? {tx_par, tx_hold_r[7:0]}
    : {1'b0, tx_par, tx_hold_r[6:0]};
  assign tx_load = run && tx_full_r && !tx_busy_r;
  assign tx_done = run && tx_busy_r && tx_div_r == 16'h0000 && tx_os_r == 4'hF
    && tx_cnt_r == 4'h0;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_hold_r <= 9'h000;
      tx_full_r <= 1'b0;
    end else if (clk_en) begin
      if (tx_load) tx_full_r <= 1'b0;
      if (data_wr) begin
        tx_hold_r <= {ctrl1_r[SMW_C1_TX9], w_data_r[7:0]};
        tx_full_r <= 1'b1;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_busy_r <= 1'b0;
      tx_sh_r <= 11'h7FF;
      tx_div_r <= 16'h0000;
      tx_os_r <= 4'h0;
      tx_cnt_r <= 4'h0;
      txd <= 1'b1;
    end else if (run) begin
      if (tx_load) begin
        tx_busy_r <= 1'b1;
        tx_sh_r <= word9 ? {1'b1, tx_word, 1'b0} : {2'b11, tx_word[7:0], 1'b0};
        tx_cnt_r <= word9 ? 4'hA : 4'h9;
        tx_div_r <= baud_r;
        tx_os_r <= 4'h0;
      end else if (tx_busy_r) begin
        txd <= tx_sh_r[0];
        tx_div_r <= tx_div_r == 16'h0000 ? baud_r : tx_div_r - 16'h0001;
        if (tx_div_r == 16'h0000) begin
          tx_os_r <= tx_os_r + 4'h1;
          if (tx_os_r == 4'hF) begin
            tx_sh_r <= {1'b1, tx_sh_r[10:1]};
            if (tx_cnt_r == 4'h0) tx_busy_r <= 1'b0;
            else tx_cnt_r <= tx_cnt_r - 4'h1;
          end
        end
      end else txd <= 1'b1;
    end
  end
  // Interrupt gating; receive sources are held off while muted
  logic [6:0] evt;
  assign evt = {status_r[SMW_TXE_BIT] & ctrl2_r[SMW_C2_TXEIRQ],
    status_r[SMW_TXC_BIT] & ctrl2_r[SMW_C2_TXCIRQ],
    status_r[SMW_RXF_BIT] & ctrl2_r[SMW_C2_RXIRQ] & !mute,
    status_r[SMW_OR_BIT] & ctrl2_r[SMW_C2_OVRIRQ] & !mute,
    status_r[SMW_IDLE_BIT] & ctrl2_r[SMW_C2_QUIETIRQ] & !mute,
    status_r[SMW_PERR_BIT] & ctrl1_r[SMW_C1_PARIRQ] & !mute,
    1'b0 & ctrl2_r[SMW_C2_LINIRQ]};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
      wait_wake <= 1'b0;
    end else if (clk_en) begin
      irq <= |evt && !cpu_int_mask && !halt_r;
      wait_wake <= |evt && wait_r && !halt_r;
    end
  end
  property p_mute_no_receive_full_flag;
    @(posedge clk) disable iff (!rst_n)
      (mute && clk_en && !rx_done) |=> !$rose(status_r[SMW_RXF_BIT]);
  endproperty
  a_mute_no_receive_full_flag: assert property (p_mute_no_receive_full_flag) else $error("flag set while muted");
  property p_idle_wake;
    @(posedge clk) disable iff (!rst_n)
      (mute && !ctrl1_r[SMW_C1_WAKE] && idle_seen) |=> !mute && !$rose(status_r[SMW_IDLE_BIT]);
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle wake wrong");
  property p_addr_wake;
    @(posedge clk) disable iff (!rst_n)
      (mute && rx_done && rx_addr && clk_en) |=> !mute;
  endproperty
  a_addr_wake: assert property (p_addr_wake) else $error("address wake missed");
  property p_irq_mask;
    @(posedge clk) disable iff (!rst_n) cpu_int_mask && clk_en |=> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
  property p_halt_quiet;
    @(posedge clk) disable iff (!rst_n) halt_r |=> $stable(tx_sh_r) && !irq;
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("activity in halt");
  property p_pe_set;
    @(posedge clk) disable iff (!rst_n)
      (accept && !status_r[SMW_RXF_BIT] && rx_par_bad && clk_en) |=> status_r[SMW_PERR_BIT];
  endproperty
  a_pe_set: assert property (p_pe_set) else $error("parity error lost");
  // A break that ends while muted must leave the mute request standing
  sequence s_muted_break;
    rx_done && rx_brk && mute && !wr_go;
  endsequence
  property p_brk_not_addr;
    @(posedge clk) disable iff (!rst_n) s_muted_break |=> mute;
  endproperty
  a_brk_not_addr: assert property (p_brk_not_addr) else $error("break taken as address");
  property p_or_clear;
    @(posedge clk) disable iff (!rst_n)
      (rx_clr && !accept && clk_en) |=> !status_r[SMW_OR_BIT] && !status_r[SMW_RXF_BIT];
  endproperty
  a_or_clear: assert property (p_or_clear) else $error("receive flags not cleared");
endmodule
`default_nettype wire

// file: verif/smw_node.sv
// Remote node on the shared serial line: sends frames to the unit, captures its frames.
// Assumes the unit's baud divider is 0, so one bit lasts 16 clocks.
`timescale 1ns/1ps
`default_nettype none
module smw_node #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk, // Bench clock
  input wire logic txd, // Line from the unit
  output logic rxd // Line toward the unit, idle high
);
  initial rxd = 1'h1;
  task automatic hold(input logic v);
    rxd <= v;
    repeat (BIT_CLKS) @(posedge clk);
  endtask
  // Start, nb bits LSB first, stop; a break keeps the stop slot low
  task automatic send(input logic [8:0] w, input int nb, input logic brk);
    hold(1'h0);
    for (int i = 0; i < nb; i++) hold(w[i]);
    hold(~brk);
    if (brk) hold(1'h1);
  endtask
  // Bit 0 start, bits 8..1 data, bit 9 stop; gives up if no start bit shows
  task automatic recv(output logic [9:0] f);
    int n;
    f = 10'h000;
    for (n = 0; n < 400 && txd; n++) @(posedge clk);
    repeat (6) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      f[i] = txd;
      repeat (BIT_CLKS) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench for the serial mute, wake-up and parity unit.
// Assumes smw_top and the line model smw_node; bus tasks run right after an edge.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import smw_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic halt_req = 1'h0, wait_req = 1'h0, cpu_int_mask = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, txd, irq, wait_wake, rxd;
  logic [1:0] bresp, rresp, rr, br;
  logic [9:0] fr;
  int err_total = 0, checks = 0;
  always #20 clk = ~clk;
  smw_top dut_u (.clk(clk), .rst_n(rst_n), .clk_en(1'h1), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rxd(rxd), .txd(txd), .halt_req(halt_req),
    .wait_req(wait_req), .cpu_int_mask(cpu_int_mask), .irq(irq), .wait_wake(wait_wake));
  smw_node node_u (.clk(clk), .txd(txd), .rxd(rxd));
  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic tmo();
    err_total++;
    results();
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic pin(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw, w;
    aw = 1'h1;
    w = 1'h1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      br = bresp;
      if (!aw && !w && bvalid) break;
      aw = aw && !awready;
      w = w && !wready;
      awvalid <= aw;
      wvalid <= w;
    end
    bready <= 1'h0;
    if (n == 50) tmo();
    @(posedge clk);
  endtask
  task automatic axr(input logic [7:0] a);
    int n;
    logic ar;
    ar = 1'h1;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (!ar && rvalid) break;
      ar = ar && !arready;
      arvalid <= ar;
    end
    rv = rdata;
    rr = rresp;
    rready <= 1'h0;
    if (n == 50) tmo();
    @(posedge clk);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    axr(a);
    cmp(nm, e, rv & m);
  endtask
  // Lets an idle line be seen, then clears every receive flag
  task automatic drain();
    repeat (200) @(posedge clk);
    axr(SMW_STATUS_OFS);
    axr(SMW_DATA_OFS);
  endtask
  task automatic t_reset();
    rd("status", SMW_STATUS_OFS, 32'hFF, {24'h0, SMW_STATUS_RST});
    rd("ctrl1", SMW_CTRL1_OFS, 32'hFF, {24'h0, SMW_CTRL1_RST});
    rd("ctrl2", SMW_CTRL2_OFS, 32'hFF, {24'h0, SMW_CTRL2_RST});
    axw(SMW_STATUS_OFS, 32'h0);
    cmp("read-only write resp", {30'h0, SMW_RESP_OKAY}, {30'h0, br});
    rd("status ro", SMW_STATUS_OFS, 32'hFF, {24'h0, SMW_STATUS_RST});
    axr(8'h20);
    cmp("unmapped resp", {30'h0, SMW_RESP_SLVERR}, {30'h0, rr});
    axw(8'h20, 32'h0);
    cmp("unmapped write resp", {30'h0, SMW_RESP_SLVERR}, {30'h0, br});
    axw(SMW_BAUD_OFS, 32'h0);
    // The divider first counts out its old reload before ticking every clock
    repeat (250) @(posedge clk);
    $display("test reset done");
  endtask
  task automatic t_parity();
    axw(SMW_CTRL1_OFS, 32'h5);
    node_u.send(9'h035, 8, 1'h0);
    repeat (4) @(posedge clk);
    rd("good parity", SMW_STATUS_OFS, 32'h3F, 32'h20);
    rd("good data", SMW_DATA_OFS, 32'hFF, 32'h35);
    node_u.send(9'h0B5, 8, 1'h0);
    repeat (4) @(posedge clk);
    pin("parity irq", 1'h1, irq);
    cpu_int_mask <= 1'h1;
    repeat (3) @(posedge clk);
    pin("masked irq", 1'h0, irq);
    rd("bad parity", SMW_STATUS_OFS, 32'h3F, 32'h21);
    axr(SMW_DATA_OFS);
    rd("flags cleared", SMW_STATUS_OFS, 32'h3F, 32'h0);
    cpu_int_mask <= 1'h0;
    drain();
    $display("test parity done");
  endtask
  task automatic t_tx();
    axw(SMW_CTRL1_OFS, 32'h6);
    axw(SMW_DATA_OFS, 32'h35);
    node_u.recv(fr);
    cmp("tx frame", 32'h36A, {22'h0, fr});
    $display("test tx done");
  endtask
  task automatic t_mute();
    axw(SMW_CTRL1_OFS, 32'h8);
    axw(SMW_CTRL2_OFS, 32'h22);
    node_u.send(9'h012, 8, 1'h0);
    node_u.send(9'h000, 8, 1'h1);
    repeat (4) @(posedge clk);
    rd("muted flags", SMW_STATUS_OFS, 32'h3F, 32'h0);
    pin("muted irq", 1'h0, irq);
    rd("break kept mute", SMW_CTRL2_OFS, 32'hFF, 32'h22);
    node_u.send(9'h093, 8, 1'h0);
    repeat (4) @(posedge clk);
    pin("address irq", 1'h1, irq);
    rd("address woke", SMW_CTRL2_OFS, 32'hFF, 32'h20);
    rd("address flag", SMW_STATUS_OFS, 32'h3F, 32'h20);
    rd("address data", SMW_DATA_OFS, 32'hFF, 32'h93);
    drain();
    $display("test mute done");
  endtask
  task automatic t_idle();
    axw(SMW_CTRL1_OFS, 32'h0);
    axw(SMW_CTRL2_OFS, 32'h12);
    node_u.send(9'h055, 8, 1'h0);
    repeat (4) @(posedge clk);
    rd("idle muted", SMW_CTRL2_OFS, 32'hFF, 32'h12);
    repeat (200) @(posedge clk);
    rd("idle woke", SMW_CTRL2_OFS, 32'hFF, 32'h10);
    rd("idle flag", SMW_STATUS_OFS, 32'h3F, 32'h0);
    $display("test idle done");
  endtask
  task automatic t_long();
    axw(SMW_CTRL2_OFS, 32'h0);
    axw(SMW_CTRL1_OFS, 32'h10);
    node_u.send(9'h1A5, 9, 1'h0);
    repeat (4) @(posedge clk);
    rd("ninth bit", SMW_CTRL1_OFS, 32'h80, 32'h80);
    rd("long flag", SMW_STATUS_OFS, 32'h3F, 32'h20);
    rd("long data", SMW_DATA_OFS, 32'hFF, 32'hA5);
    drain();
    $display("test long done");
  endtask
  task automatic t_power();
    axw(SMW_CTRL1_OFS, 32'h0);
    axw(SMW_CTRL2_OFS, 32'h8);
    halt_req <= 1'h1;
    node_u.send(9'h011, 8, 1'h0);
    halt_req <= 1'h0;
    repeat (4) @(posedge clk);
    rd("halt flags", SMW_STATUS_OFS, 32'h3F, 32'h0);
    wait_req <= 1'h1;
    node_u.send(9'h021, 8, 1'h0);
    repeat (4) @(posedge clk);
    pin("full no irq", 1'h0, irq);
    node_u.send(9'h022, 8, 1'h0);
    repeat (4) @(posedge clk);
    pin("wait wake", 1'h1, wait_wake);
    pin("overrun irq", 1'h1, irq);
    halt_req <= 1'h1;
    // Three sync stages, the agreement stage, then the registered outputs
    repeat (6) @(posedge clk);
    pin("halt no wake", 1'h0, wait_wake);
    pin("halt no irq", 1'h0, irq);
    halt_req <= 1'h0;
    wait_req <= 1'h0;
    drain();
    $display("test power done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    t_reset();
    t_parity();
    t_tx();
    t_mute();
    t_idle();
    t_long();
    t_power();
    results();
  end
endmodule
`default_nettype wire
